// >>> design/oas_pkg.sv
// constants for the operand and address size selector
// assumes a single core clock and an axi4-lite register port
package oas_pkg;
   // register byte offsets
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   // ctrl field positions
   localparam int          CTRL_CS_D_BIT  = 0;
   localparam int          CTRL_SS_B_BIT  = 1;
   localparam int          CTRL_MODE_LO   = 2;
   localparam int          CTRL_MODE_HI   = 3;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK      = 32'h0000_000F;
   // status field positions
   localparam int          ST_OP32_BIT    = 0;
   localparam int          ST_ADDR32_BIT  = 1;
   localparam int          ST_SP32_BIT    = 2;
   localparam int          ST_OFF32_BIT   = 3;
   localparam int          ST_SPHI_BIT    = 4;
   localparam int          ST_CNT_LO      = 8;
   localparam int          ST_CNT_HI      = 15;
   // execution modes
   localparam logic [1:0]  MODE_REAL      = 2'h0;
   localparam logic [1:0]  MODE_PROT      = 2'h1;
   localparam logic [1:0]  MODE_V86       = 2'h2;
   // prefix bytes
   localparam logic [7:0]  PFX_OPSIZE     = 8'h66;
   localparam logic [7:0]  PFX_ADSIZE     = 8'h67;
   // instruction kinds
   localparam logic [2:0]  KIND_PLAIN     = 3'h0;
   localparam logic [2:0]  KIND_PTR_JUMP  = 3'h1;
   localparam logic [2:0]  KIND_PTR_CALL  = 3'h2;
   localparam logic [2:0]  KIND_PTR_RET   = 3'h3;
   localparam logic [2:0]  KIND_GATE_CALL = 3'h4;
   localparam logic [2:0]  KIND_INT_GATE  = 3'h5;
   // offset limits
   localparam logic [31:0] LIMIT_WIDE     = 32'hFFFF_FFFF;
   localparam logic [31:0] LIMIT_NARROW   = 32'h0000_FFFF;
   localparam logic [15:0] HALF_ZERO      = 16'h0000;
   // axi responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // reset synchroniser states
   typedef enum logic [1:0] {
      RST_HELD = 2'b01,
      RST_RUN  = 2'b10
   } oas_rst_t;
endpackage

// >>> design/oas_top.sv
// operand size, address size and stack width selector
// assumes prefix and instruction strobes from core-clock logic,
// axi4-lite master on the same clock
// Operation
// - segment flag set gives 32, clear 16
// - real and v86 modes default to 16
// - operand prefix flips the operand size, except on gates
// - address prefix flips the address size
// - override lasts for one instruction only
// - prefixes honoured in every mode
// - both prefixes act independently
// - stack flag picks implicit stack pointer width, except on gates
// - stack flag picks expand-down upper limit
// - explicit stack accesses use address size
// - gate type sets operand and stack size
// - pointer offset sized by operand size
// - narrow far call pushes narrow pointers
// - wide far call pushes wide pointers
// - return pops at its operand size
// - narrow transfer cannot pass FFFFH
// - narrow gate call may lose upper bits
// - narrow gate carries only 16-bit offset
`timescale 1ns/10ps
module oas_top
   import oas_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              pfx_valid,
   input  wire logic [7:0]        pfx_byte,
   input  wire logic              insn_valid,
   input  wire logic [2:0]        insn_kind,
   input  wire logic              gate_32,
   input  wire logic              inter_priv,
   input  wire logic              explicit_stack,
   input  wire logic [31:0]       target_off,
   output logic                   res_valid_q,
   output logic                   op_32_q,
   output logic                   addr_32_q,
   output logic                   stk_ptr_32_q,
   output logic                   stk_addr_32_q,
   output logic [31:0]            edown_limit_q,
   output logic                   push_ip_wide_q,
   output logic                   push_sp_q,
   output logic                   pop_wide_q,
   output logic                   pop_sp_q,
   output logic                   off_32_q,
   output logic [31:0]            tgt_off_q,
   output logic                   sp_hi_unrel_q,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   logic              rst_meta_q;
   oas_rst_t          rst_state_q;
   logic              rst_sync_n;
   logic [31:0]       ctrl_q;
   logic [31:0]       status_q;
   logic [7:0]        dec_cnt_q;
   logic              opv_seen_q;
   logic              adr_seen_q;
   logic              aw_held_q;
   logic              w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              cs_d;
   logic              ss_b;
   logic [1:0]        mode;
   logic              def_32;
   logic              is_gate;
   logic              op_32_d;
   logic              addr_32_d;
   logic              sp_32_d;
   logic              off_32_d;
   logic [31:0]       tgt_off_d;
   logic              pfx_op;
   logic              pfx_ad;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q  <= 1'b0;
         rst_state_q <= RST_HELD;
      end else begin
         rst_meta_q  <= 1'b1;
         rst_state_q <= rst_meta_q ? RST_RUN : RST_HELD;
      end
   end
   assign rst_sync_n = (rst_state_q == RST_RUN);

   assign cs_d   = ctrl_q[CTRL_CS_D_BIT];
   assign ss_b   = ctrl_q[CTRL_SS_B_BIT];
   assign mode   = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
   assign pfx_op = pfx_valid && (pfx_byte == PFX_OPSIZE);
   assign pfx_ad = pfx_valid && (pfx_byte == PFX_ADSIZE);
   assign is_gate = (insn_kind == KIND_GATE_CALL) || (insn_kind == KIND_INT_GATE);

   assign def_32 = (mode == MODE_PROT) && cs_d;

   // each override flips its own size, except the operand override on gates
   assign op_32_d   = is_gate ? gate_32 : (def_32 ^ opv_seen_q);
   assign addr_32_d = def_32 ^ adr_seen_q;
   // implicit stack width from stack flag, or gate type on gates
   assign sp_32_d   = is_gate ? gate_32 : ss_b;
   assign off_32_d  = op_32_d;
   // narrow offset cut to 16 bits
   assign tgt_off_d = off_32_d ? target_off : {HALF_ZERO, target_off[15:0]};

   // repeated prefix just keeps flag set
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         opv_seen_q <= 1'b0;
         adr_seen_q <= 1'b0;
      end else begin
         if (pfx_op) begin
            opv_seen_q <= 1'b1;
         end else if (insn_valid) begin
            opv_seen_q <= 1'b0;
         end
         if (pfx_ad) begin
            adr_seen_q <= 1'b1;
         end else if (insn_valid) begin
            adr_seen_q <= 1'b0;
         end
      end
   end

   // per-instruction results
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         res_valid_q    <= 1'b0;
         op_32_q        <= 1'b0;
         addr_32_q      <= 1'b0;
         stk_ptr_32_q   <= 1'b0;
         stk_addr_32_q  <= 1'b0;
         edown_limit_q  <= LIMIT_NARROW;
         push_ip_wide_q <= 1'b0;
         push_sp_q      <= 1'b0;
         pop_wide_q     <= 1'b0;
         pop_sp_q       <= 1'b0;
         off_32_q       <= 1'b0;
         tgt_off_q      <= 32'h0000_0000;
         sp_hi_unrel_q  <= 1'b0;
      end else begin
         res_valid_q <= insn_valid;
         if (insn_valid) begin
            op_32_q       <= op_32_d;
            addr_32_q     <= addr_32_d;
            stk_ptr_32_q  <= sp_32_d;
            stk_addr_32_q <= explicit_stack ? addr_32_d : sp_32_d;
            edown_limit_q <= ss_b ? LIMIT_WIDE : LIMIT_NARROW;
            push_ip_wide_q <= op_32_d;
            push_sp_q      <= inter_priv && ((insn_kind == KIND_PTR_CALL) || is_gate);
            pop_wide_q     <= op_32_d;
            pop_sp_q       <= inter_priv && (insn_kind == KIND_PTR_RET);
            off_32_q       <= off_32_d;
            tgt_off_q      <= tgt_off_d;
            // wide caller, narrow gate, no stack switch
            sp_hi_unrel_q  <= (insn_kind == KIND_GATE_CALL) && !gate_32 &&
                              !inter_priv && def_32;
         end
      end
   end

   // status register and decode count
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         status_q  <= 32'h0000_0000;
         dec_cnt_q <= 8'h00;
      end else if (res_valid_q) begin
         dec_cnt_q                     <= dec_cnt_q + 8'h01;
         status_q                      <= 32'h0000_0000;
         status_q[ST_OP32_BIT]         <= op_32_q;
         status_q[ST_ADDR32_BIT]       <= addr_32_q;
         status_q[ST_SP32_BIT]         <= stk_ptr_32_q;
         status_q[ST_OFF32_BIT]        <= off_32_q;
         status_q[ST_SPHI_BIT]         <= sp_hi_unrel_q;
         status_q[ST_CNT_HI:ST_CNT_LO] <= dec_cnt_q + 8'h01;
      end
   end

   // axi write channel
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         ctrl_q        <= CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[7:0] == CTRL_OFS) begin
               s_axi_bresp <= RESP_OKAY;
               if (w_strb_q[0]) begin
                  ctrl_q <= w_data_q & CTRL_MASK;
               end
            end else if (aw_addr_q[7:0] == STATUS_OFS) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi read channel
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr[7:0] == CTRL_OFS) begin
               s_axi_rdata <= ctrl_q;
               s_axi_rresp <= RESP_OKAY;
            end else if (s_axi_araddr[7:0] == STATUS_OFS) begin
               s_axi_rdata <= status_q;
               s_axi_rresp <= RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_n);

   property p_mode16;
      insn_valid && (mode != MODE_PROT) && !opv_seen_q && !is_gate |=> !op_32_q;
   endproperty
   a_mode16: assert property (p_mode16) else $error("non-protected default not 16");

   property p_opflip;
      insn_valid && !is_gate |=> op_32_q == ($past(def_32) ^ $past(opv_seen_q));
   endproperty
   a_opflip: assert property (p_opflip) else $error("operand size wrong");

   property p_adflip;
      insn_valid |=> addr_32_q == ($past(def_32) ^ $past(adr_seen_q));
   endproperty
   a_adflip: assert property (p_adflip) else $error("address size wrong");

   property p_oneshot;
      insn_valid && !pfx_valid |=> !opv_seen_q && !adr_seen_q;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("override outlived insn");

   property p_gate;
      insn_valid && is_gate |=> (op_32_q == $past(gate_32)) && (stk_ptr_32_q == $past(gate_32));
   endproperty
   a_gate: assert property (p_gate) else $error("gate size not applied");

   property p_narrow;
      res_valid_q && !off_32_q |-> tgt_off_q[31:16] == HALF_ZERO;
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow offset above FFFFH");

   property p_explicit;
      insn_valid && explicit_stack |=> stk_addr_32_q == addr_32_q;
   endproperty
   a_explicit: assert property (p_explicit) else $error("explicit stack width wrong");

   property p_ret;
      insn_valid && (insn_kind == KIND_PTR_RET) |=> pop_wide_q == op_32_q;
   endproperty
   a_ret: assert property (p_ret) else $error("return pop width wrong");

   property p_edown;
      insn_valid ##1 res_valid_q |-> edown_limit_q == ($past(ss_b) ? LIMIT_WIDE : LIMIT_NARROW);
   endproperty
   a_edown: assert property (p_edown) else $error("expand-down limit wrong");

   property p_repeat;
      pfx_op ##1 (pfx_op && !insn_valid) ##1 insn_valid && !is_gate
         |=> op_32_q == !$past(def_32);
   endproperty
   a_repeat: assert property (p_repeat) else $error("double prefix reversed twice");

endmodule // oas_top

// >>> verification/oas_top_tb.sv
// self-checking bench for the operand and address size selector
// assumes registered design outputs and an axi4-lite slave on core_clk
`timescale 1ns/10ps
module oas_top_tb
   import oas_pkg::*;
;
   logic        core_clk, rst_n, pfx_valid, insn_valid, gate_32, inter_priv, explicit_stack;
   logic [7:0]  pfx_byte, s_axi_awaddr, s_axi_araddr;
   logic [2:0]  insn_kind;
   logic [31:0] target_off, s_axi_wdata, edown_limit_q, tgt_off_q, s_axi_rdata, st_exp, rdv;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        res_valid_q, op_32_q, addr_32_q, stk_ptr_32_q, stk_addr_32_q, push_ip_wide_q;
   logic        push_sp_q, pop_wide_q, pop_sp_q, off_32_q, sp_hi_unrel_q;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, cm;
   logic        ovo, ova, cd, cs;
   int          err_count, checked, cnt;

   oas_top i_oas_top (.core_clk, .rst_n, .pfx_valid, .pfx_byte, .insn_valid, .insn_kind,
      .gate_32, .inter_priv, .explicit_stack, .target_off, .res_valid_q, .op_32_q,
      .addr_32_q, .stk_ptr_32_q, .stk_addr_32_q, .edown_limit_q, .push_ip_wide_q,
      .push_sp_q, .pop_wide_q, .pop_sp_q, .off_32_q, .tgt_off_q, .sp_hi_unrel_q,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic test_done;
      $display("mismatches %0d, checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // bounded wait ran out
   task automatic tmo(input logic ok);
      if (!ok) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
         test_done();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= be;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      tmo(s_axi_bvalid === 1'b1);
      chk(s_axi_bresp, er);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      int n;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      tmo(s_axi_rvalid === 1'b1);
      chk(s_axi_rresp, er);
   endtask

   task automatic pfx(input logic [7:0] b);
      @(posedge core_clk);
      pfx_valid <= 1'b1;
      pfx_byte <= b;
      if (b == PFX_OPSIZE) ovo = 1'b1;
      if (b == PFX_ADSIZE) ova = 1'b1;
   endtask

   // one instruction, with an optional prefix in the same cycle for the next one
   task automatic insn(input logic [2:0] k, input logic g, input logic ip, input logic ex,
                       input logic wp, input logic [31:0] t);
      logic d32, gt, op, ad, sp, call, sh;
      d32 = (cm == MODE_PROT) && cd;
      gt = (k == KIND_GATE_CALL) || (k == KIND_INT_GATE);
      op = gt ? g : d32 ^ ovo;
      ad = d32 ^ ova;
      sp = gt ? g : cs;
      call = (k == KIND_PTR_CALL) || (k == KIND_GATE_CALL);
      sh = (k == KIND_GATE_CALL) && !g && !ip && d32;
      @(posedge core_clk);
      pfx_valid <= wp;
      pfx_byte <= PFX_OPSIZE;
      insn_valid <= 1'b1;
      insn_kind <= k;
      gate_32 <= g;
      inter_priv <= ip;
      explicit_stack <= ex;
      target_off <= t;
      @(posedge core_clk);
      pfx_valid <= 1'b0;
      insn_valid <= 1'b0;
      ovo = wp;
      ova = 1'b0;
      #1;
      chk(res_valid_q, 1'b1);
      chk(op_32_q, op);
      chk(addr_32_q, ad);
      chk(stk_ptr_32_q, sp);
      chk(stk_addr_32_q, ex ? ad : sp);
      chk(edown_limit_q, cs ? LIMIT_WIDE : LIMIT_NARROW);
      if (call) chk(push_ip_wide_q, op);
      chk(push_sp_q, (call || gt) && ip);
      if (k == KIND_PTR_RET) chk(pop_wide_q, op);
      chk(pop_sp_q, (k == KIND_PTR_RET) && ip);
      chk(off_32_q, op);
      chk(tgt_off_q, op ? t : {HALF_ZERO, t[15:0]});
      chk(sp_hi_unrel_q, sh);
      cnt++;
      st_exp = {16'h0000, cnt[7:0], 3'h0, sh, op, sp, ad, op};
   endtask

   initial begin
      rst_n = 1'b0;
      {pfx_valid, insn_valid, gate_32, inter_priv, explicit_stack} = 5'h00;
      {pfx_byte, insn_kind, target_off} = 43'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {ovo, ova, cd, cs, cm} = 6'h00;
      err_count = 0;
      checked = 0;
      cnt = 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(edown_limit_q, LIMIT_NARROW);
      rd(CTRL_OFS, RESP_OKAY, rdv);
      chk(rdv, CTRL_RESET);
      rd(8'h10, RESP_SLVERR, rdv);
      chk(rdv, 32'h0000_0000);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      for (int c = 0; c < 16; c++) begin
         wr(CTRL_OFS, 32'hFFFF_FFF0 | c, 4'hF, RESP_OKAY);
         {cm, cs, cd} = c[3:0];
         rd(CTRL_OFS, RESP_OKAY, rdv);
         chk(rdv, c & CTRL_MASK);
         for (int p = 0; p < 5; p++) begin
            for (int k = 0; k < 6; k++) begin
               if (p == 4) begin
                  pfx(PFX_ADSIZE);
                  pfx(8'h2E);
                  pfx(PFX_ADSIZE);
                  pfx(PFX_OPSIZE);
                  pfx(PFX_OPSIZE);
               end else begin
                  if (p[0]) pfx(PFX_OPSIZE);
                  if (p[1]) pfx(PFX_ADSIZE);
               end
               insn(k[2:0], p[1], k[0] ^ p[0], p[0], k == 3 && p == 0,
                    {12'hC35, c[3:0], 4'h7, p[3:0], 4'hA, k[3:0]});
               insn(k[2:0], !p[1], k[0], !p[0], 1'b0, {16'h0001, c[3:0], 12'h5A5});
            end
         end
         rd(STATUS_OFS, RESP_OKAY, rdv);
         chk(rdv, st_exp);
      end
      wr(STATUS_OFS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(STATUS_OFS, RESP_OKAY, rdv);
      chk(rdv, st_exp);
      wr(CTRL_OFS, 32'h0000_0005, 4'hE, RESP_OKAY);
      rd(CTRL_OFS, RESP_OKAY, rdv);
      chk(rdv, 32'h0000_000F);
      wr(CTRL_OFS, 32'h0000_0005, 4'hF, RESP_OKAY);
      {cm, cs, cd} = 4'h5;
      pfx(PFX_OPSIZE);
      insn(KIND_PTR_CALL, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0001_2345);
      pfx(PFX_OPSIZE);
      insn(KIND_PTR_RET, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0001_2345);
      // mid-run reset clears results and registers
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk(res_valid_q, 1'b0);
      chk(tgt_off_q, 32'h0000_0000);
      rd(STATUS_OFS, RESP_OKAY, rdv);
      chk(rdv, 32'h0000_0000);
      rd(CTRL_OFS, RESP_OKAY, rdv);
      chk(rdv, CTRL_RESET);
      test_done();
   end
endmodule // oas_top_tb
